/* hdl/memory_access_event_counters.sv */
// event tally top: ahb-lite register slave and two access tallies
// assumes a single ahb-lite master and access reports on i_ref_clk
// What this block does
// RULE1: two read-only 32-bit tallies, reset to zero
// RULE2: tally a counts kind chosen by bits 3-0
// RULE3: tally b counts kind chosen by bits 19-16
// RULE4: bit 31 filters tally b by requester
// RULE5: bit 30 filters tally b by space
// RULE6: bit 15 filters tally a by requester
// RULE7: bit 14 filters tally a by space
// RULE8: filter values held in own read-write register
// RULE9: space 0 external, 7 controller registers
// RULE10: plus one per match; reserved bits zero
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "tally_cfg.svh"

module memory_access_event_counters
(
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rstn,
   input  wire logic                     i_hsel,
   input  wire logic [31:0]              i_haddr,
   input  wire logic [1:0]               i_htrans,
   input  wire logic                     i_hwrite,
   input  wire logic [2:0]               i_hsize,
   input  wire logic [31:0]              i_hwdata,
   input  wire logic                     i_hready,
   output      logic [31:0]              o_hrdata,
   output      logic                     o_hreadyout,
   output      logic                     o_hresp,
   input  wire logic                     i_acc_valid,
   input  wire tally_pkg::event_kind_t   i_acc_kind,
   input  wire tally_pkg::requester_id_t i_acc_requester,
   input  wire logic                     i_acc_to_regs
);
   access_if acc_bus ();
   tally_if  t_if [2] ();

   // data phase state
   logic                dp_write;
   logic                dp_read;
   logic [`ADDR_W-1:0]  dp_addr;
   logic                next_dp_write;
   logic                next_dp_read;
   logic [`ADDR_W-1:0]  next_dp_addr;
   logic                addr_ok;

   // setup and filter value fields
   tally_pkg::event_kind_t   sel_a;
   tally_pkg::event_kind_t   sel_b;
   logic                     req_on_a;
   logic                     req_on_b;
   logic                     space_on_a;
   logic                     space_on_b;
   tally_pkg::requester_id_t req_a;
   tally_pkg::requester_id_t req_b;
   tally_pkg::space_code_t   sp_a;
   tally_pkg::space_code_t   sp_b;
   tally_pkg::event_kind_t   next_sel_a;
   tally_pkg::event_kind_t   next_sel_b;
   logic                     next_req_on_a;
   logic                     next_req_on_b;
   logic                     next_space_on_a;
   logic                     next_space_on_b;
   tally_pkg::requester_id_t next_req_a;
   tally_pkg::requester_id_t next_req_b;
   tally_pkg::space_code_t   next_sp_a;
   tally_pkg::space_code_t   next_sp_b;
   logic [31:0]              next_hrdata;
   logic [31:0]              setup_word;
   logic [31:0]              filter_word;

   access_stage u_stage
   (
      .i_ref_clk       (i_ref_clk),
      .i_rstn          (i_rstn),
      .i_acc_valid     (i_acc_valid),
      .i_acc_kind      (i_acc_kind),
      .i_acc_requester (i_acc_requester),
      .i_acc_to_regs   (i_acc_to_regs),
      .acc             (acc_bus)
   );

   for (genvar g = 0; g < 2; g++)
   begin : g_tally
      tally_unit u_tally
      (
         .i_ref_clk (i_ref_clk),
         .i_rstn    (i_rstn),
         .acc       (acc_bus),
         .ctl       (t_if[g])
      );
   end

   assign t_if[0].select      = sel_a;                      // [RULE2]
   assign t_if[0].req_on      = req_on_a;                   // [RULE6]
   assign t_if[0].space_on    = space_on_a;                 // [RULE7]
   assign t_if[0].req_match   = req_a;
   assign t_if[0].space_match = sp_a;
   assign t_if[1].select      = sel_b;                      // [RULE3]
   assign t_if[1].req_on      = req_on_b;                   // [RULE4]
   assign t_if[1].space_on    = space_on_b;                 // [RULE5]
   assign t_if[1].req_match   = req_b;
   assign t_if[1].space_match = sp_b;

   // bus: address phase capture, never waits, always okay
   always_comb
   begin
      addr_ok       = i_hsel && i_htrans[1] && i_hready;
      next_dp_write = addr_ok && i_hwrite;
      next_dp_read  = addr_ok && !i_hwrite;
      next_dp_addr  = addr_ok ? i_haddr[`ADDR_W-1:0] : dp_addr;
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         dp_write    <= 1'b0;
         dp_read     <= 1'b0;
         dp_addr     <= 8'h00;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
      else
      begin
         dp_write    <= next_dp_write;
         dp_read     <= next_dp_read;
         dp_addr     <= next_dp_addr;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
   end

   // register writes land at the end of the data phase
   always_comb
   begin
      next_sel_a      = sel_a;
      next_sel_b      = sel_b;
      next_req_on_a   = req_on_a;
      next_req_on_b   = req_on_b;
      next_space_on_a = space_on_a;
      next_space_on_b = space_on_b;
      next_req_a      = req_a;
      next_req_b      = req_b;
      next_sp_a       = sp_a;
      next_sp_b       = sp_b;
      if (dp_write && dp_addr == `OFS_SETUP)
      begin
         next_sel_a      = i_hwdata[`SEL_A_LSB +: `SEL_W];  // [RULE2]
         next_sel_b      = i_hwdata[`SEL_B_LSB +: `SEL_W];  // [RULE3]
         next_req_on_b   = i_hwdata[`REQF_B_BIT];           // [RULE4]
         next_space_on_b = i_hwdata[`SPF_B_BIT];            // [RULE5]
         next_req_on_a   = i_hwdata[`REQF_A_BIT];           // [RULE6]
         next_space_on_a = i_hwdata[`SPF_A_BIT];            // [RULE7]
      end
      if (dp_write && dp_addr == `OFS_FILTER)
      begin
         next_req_b = i_hwdata[`REQM_B_LSB +: `REQ_W];      // [RULE8]
         next_sp_b  = i_hwdata[`SPM_B_LSB +: `SPACE_W];     // [RULE8]
         next_req_a = i_hwdata[`REQM_A_LSB +: `REQ_W];      // [RULE8]
         next_sp_a  = i_hwdata[`SPM_A_LSB +: `SPACE_W];     // [RULE8]
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         sel_a      <= `SEL_A_RST;                          // [RULE2]
         sel_b      <= `SEL_B_RST;                          // [RULE3]
         req_on_a   <= 1'b0;
         req_on_b   <= 1'b0;
         space_on_a <= 1'b0;
         space_on_b <= 1'b0;
         req_a      <= 8'h00;                               // [RULE8]
         req_b      <= 8'h00;
         sp_a       <= 4'h0;
         sp_b       <= 4'h0;
      end
      else
      begin
         sel_a      <= next_sel_a;
         sel_b      <= next_sel_b;
         req_on_a   <= next_req_on_a;
         req_on_b   <= next_req_on_b;
         space_on_a <= next_space_on_a;
         space_on_b <= next_space_on_b;
         req_a      <= next_req_a;
         req_b      <= next_req_b;
         sp_a       <= next_sp_a;
         sp_b       <= next_sp_b;
      end
   end

   // read data built from next values, so a write just before shows
   always_comb
   begin
      setup_word  = {next_req_on_b, next_space_on_b, 10'h000, next_sel_b,
                     next_req_on_a, next_space_on_a, 10'h000, next_sel_a};
      filter_word = {next_req_b, 4'h0, next_sp_b,
                     next_req_a, 4'h0, next_sp_a};
      next_hrdata = 32'h00000000;
      if (next_dp_read)
      begin
         // unmapped offsets read zero; high address bits are not decoded
         case (next_dp_addr)
            `OFS_TALLY_A: next_hrdata = t_if[0].count;      // [RULE1]
            `OFS_TALLY_B: next_hrdata = t_if[1].count;      // [RULE1]
            `OFS_SETUP:   next_hrdata = setup_word;         // [RULE10]
            `OFS_FILTER:  next_hrdata = filter_word;        // [RULE10]
            default:      next_hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_hrdata <= 32'h00000000;
      else
         o_hrdata <= next_hrdata;
   end

   property p_tally_a_step;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      t_if[0].hit |=> t_if[0].count == $past(t_if[0].count) + 32'h1;
   endproperty
   a_tally_a_step: assert property (p_tally_a_step) // [RULE1]
      else $error("tally a did not step by one on a match");

   property p_tally_b_hold;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !t_if[1].hit |=> $stable(t_if[1].count);
   endproperty
   a_tally_b_hold: assert property (p_tally_b_hold) // [RULE10]
      else $error("tally b moved without a match");

   property p_kind_a;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      t_if[0].hit |-> acc_bus.valid && acc_bus.kind == sel_a;
   endproperty
   a_kind_a: assert property (p_kind_a) // [RULE2]
      else $error("tally a counted a foreign kind");

   property p_sel_b_write;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      dp_write && dp_addr == `OFS_SETUP
      |=> sel_b == $past(i_hwdata[19:16]) ##1 t_if[1].select == sel_b;
   endproperty
   a_sel_b_write: assert property (p_sel_b_write) // [RULE3]
      else $error("tally b selector not taken from write");

   property p_req_b;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      t_if[1].hit && req_on_b |-> acc_bus.requester == req_b;
   endproperty
   a_req_b: assert property (p_req_b) // [RULE4]
      else $error("tally b counted another requester");

   property p_space_b;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      t_if[1].hit && space_on_b
      |-> (sp_b == `SPACE_EXT && !acc_bus.to_regs)
          || (sp_b == `SPACE_REGS && acc_bus.to_regs);
   endproperty
   a_space_b: assert property (p_space_b) // [RULE5]
      else $error("tally b counted another space");

   property p_req_a;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      acc_bus.valid && acc_bus.kind == sel_a && !space_on_a
      && acc_bus.requester == req_a |-> t_if[0].hit;
   endproperty
   a_req_a: assert property (p_req_a) // [RULE6]
      else $error("tally a missed a matching requester");

   property p_space_a_off;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      acc_bus.valid && acc_bus.kind == sel_a && !space_on_a && !req_on_a
      |-> t_if[0].hit;
   endproperty
   a_space_a_off: assert property (p_space_a_off) // [RULE7]
      else $error("tally a filtered with filters off");

   // a single master never overlaps phases: the read's data phase
   // comes two edges after the write's data phase
   property p_filter_read;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      dp_write && dp_addr == `OFS_FILTER ##2 dp_read
      && dp_addr == `OFS_FILTER
      |-> o_hrdata == ($past(i_hwdata, 2) & ~`FILTER_RSVD_MASK);
   endproperty
   a_filter_read: assert property (p_filter_read) // [RULE8]
      else $error("filter values did not read back");

   property p_space_reserved;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      space_on_b && sp_b != `SPACE_EXT && sp_b != `SPACE_REGS
      |-> !t_if[1].hit;
   endproperty
   a_space_reserved: assert property (p_space_reserved) // [RULE9]
      else $error("reserved space code matched");

   property p_setup_rsvd;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      dp_read && dp_addr == `OFS_SETUP
      |-> (o_hrdata & `SETUP_RSVD_MASK) == 32'h0 && o_hreadyout;
   endproperty
   a_setup_rsvd: assert property (p_setup_rsvd) // [RULE10]
      else $error("reserved setup bits read nonzero");

endmodule : memory_access_event_counters

/* hdl/tally_cfg.svh */
// offsets, field positions and reset values of the event tally block
// assumes a 32-bit register bus with word-aligned registers
`ifndef TALLY_CFG_SVH
`define TALLY_CFG_SVH

// byte offsets inside the block's own address window
`define ADDR_W           8
`define OFS_TALLY_A      8'h00
`define OFS_TALLY_B      8'h04
`define OFS_SETUP        8'h08
`define OFS_FILTER       8'h0c

// setup register fields
`define SEL_A_LSB        0
`define SPF_A_BIT        14
`define REQF_A_BIT       15
`define SEL_B_LSB        16
`define SPF_B_BIT        30
`define REQF_B_BIT       31
`define SEL_W            4
`define SEL_A_RST        4'h0
`define SEL_B_RST        4'h1
`define SETUP_RSVD_MASK  32'h3ff03ff0

// filter value register fields
`define SPM_A_LSB        0
`define REQM_A_LSB       8
`define SPM_B_LSB        16
`define REQM_B_LSB       24
`define REQ_W            8
`define SPACE_W          4
`define FILTER_RSVD_MASK 32'h00f000f0

// memory space codes
`define SPACE_EXT        4'h0
`define SPACE_REGS       4'h7

`define TALLY_W          32
`define TALLY_RST        32'h00000000

`endif

/* hdl/tally_pkg.sv */
// types shared by the event tally block
// assumes nothing of its surroundings
package tally_pkg;
   typedef logic [3:0]  event_kind_t;
   typedef logic [7:0]  requester_id_t;
   typedef logic [3:0]  space_code_t;
   typedef logic [31:0] tally_t;
endpackage : tally_pkg

/* hdl/tally_ifs.sv */
// carriers between the tally top and its counter and access stage
// assumes one clock shared by all ends
`timescale 1ns/1ps

interface access_if;
   logic                    valid;
   tally_pkg::event_kind_t  kind;
   tally_pkg::requester_id_t requester;
   logic                    to_regs;
   modport src (output valid, output kind, output requester,
                output to_regs);
   modport dst (input valid, input kind, input requester, input to_regs);
endinterface : access_if

interface tally_if;
   tally_pkg::event_kind_t   select;
   logic                     req_on;
   logic                     space_on;
   tally_pkg::requester_id_t req_match;
   tally_pkg::space_code_t   space_match;
   tally_pkg::tally_t        count;
   logic                     hit;
   modport cfg  (output select, output req_on, output space_on,
                 output req_match, output space_match,
                 input count, input hit);
   modport unit (input select, input req_on, input space_on,
                 input req_match, input space_match,
                 output count, output hit);
endinterface : tally_if

/* hdl/access_stage.sv */
// one register stage for access reports from the bus masters
// assumes reports come from logic on the same clock
`timescale 1ns/1ps

module access_stage
(
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_rstn,
   input  wire logic                     i_acc_valid,
   input  wire tally_pkg::event_kind_t   i_acc_kind,
   input  wire tally_pkg::requester_id_t i_acc_requester,
   input  wire logic                     i_acc_to_regs,
   access_if.src                         acc
);
   logic                     next_valid;
   tally_pkg::event_kind_t   next_kind;
   tally_pkg::requester_id_t next_requester;
   logic                     next_to_regs;

   always_comb
   begin
      next_valid     = i_acc_valid;
      next_kind      = i_acc_kind;
      next_requester = i_acc_requester;
      next_to_regs   = i_acc_to_regs;
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         acc.valid     <= 1'b0;
         acc.kind      <= 4'h0;
         acc.requester <= 8'h00;
         acc.to_regs   <= 1'b0;
      end
      else
      begin
         acc.valid     <= next_valid;
         acc.kind      <= next_kind;
         acc.requester <= next_requester;
         acc.to_regs   <= next_to_regs;
      end
   end
endmodule : access_stage

/* hdl/tally_unit.sv */
// one event tally: match logic and 32-bit counter
// assumes settings are stable registers of the same clock
`timescale 1ns/1ps
`include "tally_cfg.svh"

module tally_unit
(
   input  wire logic i_ref_clk,
   input  wire logic i_rstn,
   access_if.dst     acc,
   tally_if.unit     ctl
);
   logic              space_ok;
   logic              req_ok;
   tally_pkg::tally_t next_count;

   always_comb
   begin
      // reserved space codes never match
      case (ctl.space_match)
         `SPACE_EXT:  space_ok = !acc.to_regs;              // [RULE9]
         `SPACE_REGS: space_ok = acc.to_regs;               // [RULE9]
         default:     space_ok = 1'b0;
      endcase
      req_ok  = (acc.requester == ctl.req_match);
      ctl.hit = acc.valid && (acc.kind == ctl.select)
                && (!ctl.req_on || req_ok)
                && (!ctl.space_on || space_ok);
      // wraps silently at the top, no saturation
      next_count = ctl.hit ? ctl.count + 32'h00000001 : ctl.count; // [RULE10]
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         ctl.count <= `TALLY_RST;                           // [RULE1]
      else
         ctl.count <= next_count;
   end
endmodule : tally_unit

/* dv/access_source.sv */
// stand-in for the bus masters that report memory accesses
// assumes the bench calls send just after a rising edge of i_ref_clk
`timescale 1ns/1ps

module access_source
(
   input  wire logic                      i_ref_clk,
   output      logic                      o_acc_valid,
   output      tally_pkg::event_kind_t    o_acc_kind,
   output      tally_pkg::requester_id_t  o_acc_requester,
   output      logic                      o_acc_to_regs
);
   initial
   begin
      o_acc_valid     = 1'b0;
      o_acc_kind      = 4'h0;
      o_acc_requester = 8'h00;
      o_acc_to_regs   = 1'b0;
   end

   // idle lines show the inverse so stale values never pass for a match
   task automatic send(input tally_pkg::event_kind_t k,
                       input tally_pkg::requester_id_t r,
                       input logic g, input int n, input int gap);
      for (int i = 0; i < n; i++)
      begin
         o_acc_valid     <= 1'b1;
         o_acc_kind      <= k;
         o_acc_requester <= r;
         o_acc_to_regs   <= g;
         @(posedge i_ref_clk);
         if (gap > 0)
         begin
            o_acc_valid     <= 1'b0;
            o_acc_kind      <= ~k;
            o_acc_requester <= ~r;
            o_acc_to_regs   <= ~g;
            repeat (gap) @(posedge i_ref_clk);
         end
      end
      o_acc_valid     <= 1'b0;
      o_acc_kind      <= ~k;
      o_acc_requester <= ~r;
      o_acc_to_regs   <= ~g;
   endtask : send
endmodule : access_source

/* dv/test_memory_access_event_counters.sv */
// self-checking bench for the event tally block
// assumes one ahb-lite master (this bench) and the access_source model
`timescale 1ns/1ps
`include "tally_cfg.svh"

module test_memory_access_event_counters;
   logic                     i_ref_clk;
   logic                     i_rstn;
   logic                     i_hsel;
   logic [31:0]              i_haddr;
   logic [1:0]               i_htrans;
   logic                     i_hwrite;
   logic [2:0]               i_hsize;
   logic [31:0]              i_hwdata;
   logic [31:0]              o_hrdata;
   logic                     o_hreadyout;
   logic                     o_hresp;
   logic                     acc_valid;
   tally_pkg::event_kind_t   acc_kind;
   tally_pkg::requester_id_t acc_requester;
   logic                     acc_to_regs;
   int                       err_total;
   int                       compares;
   logic [31:0]              exp_a;
   logic [31:0]              exp_b;

   memory_access_event_counters dut
   (
      .i_ref_clk       (i_ref_clk),
      .i_rstn          (i_rstn),
      .i_hsel          (i_hsel),
      .i_haddr         (i_haddr),
      .i_htrans        (i_htrans),
      .i_hwrite        (i_hwrite),
      .i_hsize         (i_hsize),
      .i_hwdata        (i_hwdata),
      .i_hready        (o_hreadyout),
      .o_hrdata        (o_hrdata),
      .o_hreadyout     (o_hreadyout),
      .o_hresp         (o_hresp),
      .i_acc_valid     (acc_valid),
      .i_acc_kind      (acc_kind),
      .i_acc_requester (acc_requester),
      .i_acc_to_regs   (acc_to_regs)
   );

   access_source src
   (
      .i_ref_clk       (i_ref_clk),
      .o_acc_valid     (acc_valid),
      .o_acc_kind      (acc_kind),
      .o_acc_requester (acc_requester),
      .o_acc_to_regs   (acc_to_regs)
   );

   initial
   begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end

   task automatic finish_test;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // bounded wait for hready at a rising edge
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge i_ref_clk);
      while (o_hreadyout !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            err_total++;
            finish_test();
         end
         @(posedge i_ref_clk);
      end
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      i_haddr  <= {24'h000000, a};
      i_hwrite <= wr;
      i_htrans <= 2'h2;
      wait_ready();
      i_htrans <= 2'h0;
      i_hwdata <= wd;
      wait_ready();
      rd = o_hrdata;
      check({31'h0, o_hresp}, 32'h0);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      bus(1'b1, a, d, unused);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      check(d, exp);
   endtask : rd_chk

   // two spare edges so the staged event reaches the tally before a read
   task automatic ev(input logic [3:0] k, input logic [7:0] r,
                     input logic g, input int n, input int gap);
      src.send(k, r, g, n, gap);
      repeat (2) @(posedge i_ref_clk);
   endtask : ev

   task automatic test_reset;
      rd_chk(`OFS_TALLY_A, 32'h00000000);
      rd_chk(`OFS_TALLY_B, 32'h00000000);
      rd_chk(`OFS_SETUP, 32'h00010000);
      rd_chk(`OFS_FILTER, 32'h00000000);
      rd_chk(8'h10, 32'h00000000);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_access;
      wr(`OFS_SETUP, 32'hffffffff);
      rd_chk(`OFS_SETUP, 32'hc00fc00f);
      wr(`OFS_FILTER, 32'hffffffff);
      rd_chk(`OFS_FILTER, 32'hff0fff0f);
      wr(`OFS_TALLY_A, 32'h12345678);
      wr(`OFS_TALLY_B, 32'h9abcdef0);
      rd_chk(`OFS_TALLY_A, 32'h00000000);
      rd_chk(`OFS_TALLY_B, 32'h00000000);
      wr(`OFS_SETUP, 32'h00000000);
      wr(`OFS_FILTER, 32'h00000000);
      $display("test_access done");
   endtask : test_access

   // every kind code on both tallies, never the same kind on both
   task automatic test_kinds;
      for (int k = 0; k < 16; k++)
      begin
         wr(`OFS_SETUP, {12'h000, 4'(15 - k), 12'h000, 4'(k)});
         ev(4'(k), 8'h11, 1'b0, 2, 0);
         ev(4'(15 - k), 8'h22, 1'b1, 1, 1);
         exp_a = exp_a + 32'h2;
         exp_b = exp_b + 32'h1;
         rd_chk(`OFS_TALLY_A, exp_a);
         rd_chk(`OFS_TALLY_B, exp_b);
      end
      $display("test_kinds done");
   endtask : test_kinds

   task automatic test_requester;
      wr(`OFS_FILTER, 32'h3c005a00);
      wr(`OFS_SETUP, 32'h00028002);
      ev(4'h2, 8'h5a, 1'b0, 3, 1);
      ev(4'h2, 8'ha5, 1'b0, 2, 0);
      exp_a = exp_a + 32'h3;
      exp_b = exp_b + 32'h5;
      rd_chk(`OFS_TALLY_A, exp_a);
      rd_chk(`OFS_TALLY_B, exp_b);
      wr(`OFS_SETUP, 32'h80020002);
      ev(4'h2, 8'h3c, 1'b1, 1, 0);
      ev(4'h2, 8'h5a, 1'b1, 2, 0);
      exp_a = exp_a + 32'h3;
      exp_b = exp_b + 32'h1;
      rd_chk(`OFS_TALLY_A, exp_a);
      rd_chk(`OFS_TALLY_B, exp_b);
      $display("test_requester done");
   endtask : test_requester

   task automatic test_space;
      wr(`OFS_FILTER, 32'h00070000);
      wr(`OFS_SETUP, 32'h40064006);
      ev(4'h6, 8'h01, 1'b0, 2, 0);
      ev(4'h6, 8'h02, 1'b1, 3, 2);
      exp_a = exp_a + 32'h2;
      exp_b = exp_b + 32'h3;
      rd_chk(`OFS_TALLY_A, exp_a);
      rd_chk(`OFS_TALLY_B, exp_b);
      // reserved space code matches neither kind of target
      wr(`OFS_FILTER, 32'h00030003);
      ev(4'h6, 8'h03, 1'b0, 2, 0);
      ev(4'h6, 8'h04, 1'b1, 2, 0);
      rd_chk(`OFS_TALLY_A, exp_a);
      rd_chk(`OFS_TALLY_B, exp_b);
      $display("test_space done");
   endtask : test_space

   // second reset while tallies and settings hold live values
   task automatic test_rerun;
      i_rstn <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      test_reset();
      $display("test_rerun done");
   endtask : test_rerun

   initial
   begin
      err_total = 0;
      compares  = 0;
      exp_a     = 32'h0;
      exp_b     = 32'h0;
      i_rstn    = 1'b0;
      i_hsel    = 1'b1;
      i_haddr   = 32'h0;
      i_htrans  = 2'h0;
      i_hwrite  = 1'b0;
      i_hsize   = 3'h2;
      i_hwdata  = 32'h0;
      repeat (6) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      test_reset();
      test_access();
      test_kinds();
      test_requester();
      test_space();
      test_rerun();
      finish_test();
   end
endmodule : test_memory_access_event_counters
